// [rtl/sinfo_regs.sv]
`timescale 1ns/1ps
`default_nettype none
`include "sinfo_params.svh"
module sinfo_regs #(
	parameter logic FEAT_BYTEMAP   = 1'b1,
	parameter logic FEAT_DC        = 1'b1,
	parameter logic FEAT_DC64      = 1'b1,
	parameter logic FEAT_ELD_MII   = 1'b0,
	parameter logic FEAT_FCS_SEP   = 1'b0,
	parameter logic FEAT_SYNC_ACT  = 1'b0,
	parameter logic FEAT_NO_LRW    = 1'b0,
	parameter logic FEAT_NO_RW     = 1'b0,
	parameter logic FEAT_FIXED_CFG = 1'b0
) (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        frameStart,
	input  wire logic        frameEnd,
	input  wire logic        netRead,
	input  wire logic        netWrite,
	input  wire logic [15:0] netAddr,
	input  wire logic [7:0]  netWdata,
	output var  logic [7:0]  netRdata,
	output var  logic        netWriteAck,
	input  wire logic        hostRead,
	input  wire logic        hostWrite,
	input  wire logic [15:0] hostAddr,
	input  wire logic [7:0]  hostWdata,
	output var  logic [7:0]  hostRdata,
	input  wire logic        eepromLoad,
	input  wire logic [15:0] eepromAlias,
	input  wire logic        aliasEnable,
	input  wire logic [15:0] cmdAddr,
	output var  logic        addrMatch,
	output var  logic        guardActive
);
	localparam logic [15:0] STADDR_RST = `SINFO_STADDR_RST;
	localparam logic [15:0] ALIAS_RST  = `SINFO_ALIAS_RST;

	logic [7:0]  staLo_reg;
	logic [7:0]  staLo_next;
	logic [7:0]  staHi_reg;
	logic [7:0]  staHi_next;
	logic [7:0]  aliasLo_reg;
	logic [7:0]  aliasLo_next;
	logic [7:0]  aliasHi_reg;
	logic [7:0]  aliasHi_next;
	logic [7:0]  netRdata_reg;
	logic [7:0]  netRdata_next;
	logic [7:0]  hostRdata_reg;
	logic [7:0]  hostRdata_next;
	logic        ack_reg;
	logic        ack_next;
	logic        match_reg;
	logic        match_next;
	logic        guardOut_reg;
	logic        guardOut_next;
	sinfo_pkg::sinfo_load_type ld_reg;
	sinfo_pkg::sinfo_load_type ld_next;
	logic        guardOn;
	logic        netWriteAllowed;
	logic [15:0] staddr;
	logic [15:0] aliasVal;

	sinfo_guard u_guard (
		.clk_sys         (clk_sys),
		.rst_n           (rst_n),
		.frameStart      (frameStart),
		.frameEnd        (frameEnd),
		.netWrite        (netWrite),
		.netAddr         (netAddr),
		.netWdata        (netWdata),
		.guardOn         (guardOn),
		.netWriteAllowed (netWriteAllowed)
	);

	wire [7:0] portDesc = {4'h0, `SINFO_PORT_MII, `SINFO_PORT_MII};
	wire [15:0] features = {
		4'h0,
		FEAT_FIXED_CFG,
		FEAT_NO_RW,
		FEAT_NO_LRW,
		FEAT_SYNC_ACT,
		FEAT_FCS_SEP,
		FEAT_ELD_MII,
		1'b0,
		1'b0,
		FEAT_DC64,
		FEAT_DC,
		1'b0,
		FEAT_BYTEMAP
	};

	// shared read mux: both sides see the same map
	function automatic logic [7:0] readByte(input logic [15:0] a, input logic [15:0] sa,
		input logic [15:0] al, input logic g);
		case (a)
			`SINFO_ADDR_BMCOUNT:   readByte = `SINFO_BMCOUNT_VAL;
			`SINFO_ADDR_RAMSIZE:   readByte = `SINFO_RAMSIZE_VAL;
			`SINFO_ADDR_PORTDESC:  readByte = portDesc;
			`SINFO_ADDR_FEAT_LO:   readByte = features[7:0];
			`SINFO_ADDR_FEAT_HI:   readByte = features[15:8];
			`SINFO_ADDR_STADDR_LO: readByte = sa[7:0];
			`SINFO_ADDR_STADDR_HI: readByte = sa[15:8];
			`SINFO_ADDR_ALIAS_LO:  readByte = al[7:0];
			`SINFO_ADDR_ALIAS_HI:  readByte = al[15:8];
			`SINFO_ADDR_UNLOCK:    readByte = 8'h00;
			`SINFO_ADDR_GUARD:     readByte = {7'h00, g};
			default:               readByte = 8'h00;
		endcase
	endfunction

	// write rights per side; read-only and unlisted bytes refuse both sides
	function automatic logic mayWrite(input sinfo_pkg::sinfo_side_type s,
		input logic [15:0] a);
		case (a)
			`SINFO_ADDR_STADDR_LO,
			`SINFO_ADDR_STADDR_HI: mayWrite = (s == sinfo_pkg::SINFO_SIDE_NET);
			`SINFO_ADDR_ALIAS_LO,
			`SINFO_ADDR_ALIAS_HI:  mayWrite = (s == sinfo_pkg::SINFO_SIDE_HOST);
			`SINFO_ADDR_UNLOCK,
			`SINFO_ADDR_GUARD:     mayWrite = (s == sinfo_pkg::SINFO_SIDE_NET);
			default:               mayWrite = 1'b0;
		endcase
	endfunction

	// a write beats the eeprom copy, which beats the held value
	function automatic logic [7:0] nextByte(input logic [7:0] q, input logic wr,
		input logic [7:0] d, input logic ld, input logic [7:0] ldv);
		if (wr) begin
			nextByte = d;
		end else if (ld) begin
			nextByte = ldv;
		end else begin
			nextByte = q;
		end
	endfunction

	wire netMayWr  = mayWrite(sinfo_pkg::SINFO_SIDE_NET, netAddr);
	wire hostMayWr = mayWrite(sinfo_pkg::SINFO_SIDE_HOST, hostAddr);
	wire netWrOk   = netWrite && netWriteAllowed;
	wire wrStaLo   = netWrOk && netMayWr && (netAddr == `SINFO_ADDR_STADDR_LO);
	wire wrStaHi   = netWrOk && netMayWr && (netAddr == `SINFO_ADDR_STADDR_HI);
	wire wrAliasLo = hostWrite && hostMayWr && (hostAddr == `SINFO_ADDR_ALIAS_LO);
	wire wrAliasHi = hostWrite && hostMayWr && (hostAddr == `SINFO_ADDR_ALIAS_HI);
	wire firstLoad = eepromLoad && (ld_reg == sinfo_pkg::SINFO_LD_IDLE);
	// alias only counts when link-layer control enables it
	wire aliasHit  = aliasEnable && (cmdAddr == aliasVal);
	wire staHit    = (cmdAddr == staddr);

	assign staddr         = {staHi_reg, staLo_reg};
	assign aliasVal       = {aliasHi_reg, aliasLo_reg};
	assign staLo_next     = nextByte(staLo_reg, wrStaLo, netWdata, 1'b0, 8'h00);
	assign staHi_next     = nextByte(staHi_reg, wrStaHi, netWdata, 1'b0, 8'h00);
	// host write wins over a coincident eeprom copy: software intent is newer
	assign aliasLo_next   = nextByte(aliasLo_reg, wrAliasLo, hostWdata, firstLoad,
		eepromAlias[7:0]);
	assign aliasHi_next   = nextByte(aliasHi_reg, wrAliasHi, hostWdata, firstLoad,
		eepromAlias[15:8]);
	assign netRdata_next  = netRead ? readByte(netAddr, staddr, aliasVal, guardOn) : 8'h00;
	assign hostRdata_next = hostRead ? readByte(hostAddr, staddr, aliasVal, guardOn) : 8'h00;
	assign ack_next       = netWrOk;
	assign match_next     = staHit || aliasHit;
	assign guardOut_next  = guardOn;

	// the first load is consumed even when a host write wins its cycle
	always_comb begin
		case (ld_reg)
			sinfo_pkg::SINFO_LD_IDLE: begin
				ld_next = eepromLoad ? sinfo_pkg::SINFO_LD_FIRST : sinfo_pkg::SINFO_LD_IDLE;
			end
			sinfo_pkg::SINFO_LD_FIRST: begin
				ld_next = sinfo_pkg::SINFO_LD_DONE;
			end
			sinfo_pkg::SINFO_LD_DONE: begin
				ld_next = sinfo_pkg::SINFO_LD_DONE;
			end
			default: begin
				ld_next = sinfo_pkg::SINFO_LD_DONE;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			staLo_reg <= STADDR_RST[7:0];
			staHi_reg <= STADDR_RST[15:8];
		end else begin
			staLo_reg <= staLo_next;
			staHi_reg <= staHi_next;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			aliasLo_reg <= ALIAS_RST[7:0];
			aliasHi_reg <= ALIAS_RST[15:8];
		end else begin
			aliasLo_reg <= aliasLo_next;
			aliasHi_reg <= aliasHi_next;
		end
	end

	// only a power-on style reset rearms the first-load copy
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ld_reg <= sinfo_pkg::SINFO_LD_IDLE;
		end else begin
			ld_reg <= ld_next;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			netRdata_reg <= 8'h00;
		end else begin
			netRdata_reg <= netRdata_next;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			hostRdata_reg <= 8'h00;
		end else begin
			hostRdata_reg <= hostRdata_next;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= ack_next;
		end
	end

	// registered match costs a cycle but keeps the output glitch-free
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			match_reg <= 1'b0;
		end else begin
			match_reg <= match_next;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			guardOut_reg <= 1'b0;
		end else begin
			guardOut_reg <= guardOut_next;
		end
	end

	assign netRdata    = netRdata_reg;
	assign hostRdata   = hostRdata_reg;
	assign netWriteAck = ack_reg;
	assign addrMatch   = match_reg;
	assign guardActive = guardOut_reg;
endmodule // sinfo_regs
`default_nettype wire

// [rtl/sinfo_params.svh]
`ifndef SINFO_PARAMS_SVH
`define SINFO_PARAMS_SVH

`define SINFO_ADDR_BMCOUNT    16'h0005
`define SINFO_ADDR_RAMSIZE    16'h0006
`define SINFO_ADDR_PORTDESC   16'h0007
`define SINFO_ADDR_FEAT_LO    16'h0008
`define SINFO_ADDR_FEAT_HI    16'h0009
`define SINFO_ADDR_STADDR_LO  16'h0010
`define SINFO_ADDR_STADDR_HI  16'h0011
`define SINFO_ADDR_ALIAS_LO   16'h0012
`define SINFO_ADDR_ALIAS_HI   16'h0013
`define SINFO_ADDR_UNLOCK     16'h0020
`define SINFO_ADDR_GUARD      16'h0021

`define SINFO_PROT_A_LO       16'h0000
`define SINFO_PROT_A_HI       16'h0137
`define SINFO_PROT_B_LO       16'h013A
`define SINFO_PROT_B_HI       16'h0F0F
`define SINFO_PROT_EXEMPT     16'h0030

`define SINFO_BMCOUNT_VAL     8'h08
`define SINFO_RAMSIZE_VAL     8'h10
`define SINFO_PORT_MII        2'h3
`define SINFO_PORT0_LSB       0
`define SINFO_PORT1_LSB       2

`define SINFO_FEAT_BYTEMAP    0
`define SINFO_FEAT_DC         2
`define SINFO_FEAT_DC64       3
`define SINFO_FEAT_LJ_BP      4
`define SINFO_FEAT_ELD_BP     5
`define SINFO_FEAT_ELD_MII    6
`define SINFO_FEAT_FCS_SEP    7
`define SINFO_FEAT_SYNC_ACT   8
`define SINFO_FEAT_NO_LRW     9
`define SINFO_FEAT_NO_RW      10
`define SINFO_FEAT_FIXED_CFG  11

`define SINFO_STADDR_RST      16'h0000
`define SINFO_ALIAS_RST       16'h0000
`define SINFO_GUARD_BIT       0

`endif

// [rtl/sinfo_pkg.sv]
package sinfo_pkg;
	typedef enum logic [1:0] {
		SINFO_SIDE_NET  = 2'h1,
		SINFO_SIDE_HOST = 2'h2
	} sinfo_side_type;

	typedef enum logic [2:0] {
		SINFO_LD_IDLE  = 3'h1,
		SINFO_LD_FIRST = 3'h2,
		SINFO_LD_DONE  = 3'h4
	} sinfo_load_type;
endpackage

// [rtl/sinfo_guard.sv]
`timescale 1ns/1ps
`default_nettype none
`include "sinfo_params.svh"
module sinfo_guard (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        frameStart,
	input  wire logic        frameEnd,
	input  wire logic        netWrite,
	input  wire logic [15:0] netAddr,
	input  wire logic [7:0]  netWdata,
	output var  logic        guardOn,
	output wire logic        netWriteAllowed
);
	logic guard_reg;
	logic guard_next;
	logic unlocked_reg;
	logic unlocked_next;

	function automatic logic inProtected(input logic [15:0] a);
		inProtected = (a != `SINFO_PROT_EXEMPT) &&
			((a <= `SINFO_PROT_A_HI) ||
			((a >= `SINFO_PROT_B_LO) && (a <= `SINFO_PROT_B_HI)));
	endfunction

	wire isUnlockWr = netWrite && (netAddr == `SINFO_ADDR_UNLOCK);
	wire isGuardWr  = netWrite && (netAddr == `SINFO_ADDR_GUARD);
	// unlock write itself is always accepted so a locked master can open the frame
	assign netWriteAllowed = !guard_reg || unlocked_reg || isUnlockWr ||
		!inProtected(netAddr);
	assign guardOn = guard_reg;

	// only bit 0 kept; reserved bits dropped
	assign guard_next = (isGuardWr && netWriteAllowed) ?
		netWdata[`SINFO_GUARD_BIT] : guard_reg;
	// unlock dies at frame boundaries, so it spans one frame only
	assign unlocked_next = (frameStart || frameEnd) ? 1'b0 :
		(isUnlockWr ? 1'b1 : unlocked_reg);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			guard_reg    <= 1'b0;
			unlocked_reg <= 1'b0;
		end else begin
			guard_reg    <= guard_next;
			unlocked_reg <= unlocked_next;
		end
	end
endmodule // sinfo_guard
`default_nettype wire

// [verification/sinfo_frame_model.sv]
`timescale 1ns/1ps
`default_nettype none
// frame bounds and EEPROM loads, one registered pulse per request
module sinfo_frame_model (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic        openReq,
	input  wire logic        closeReq,
	input  wire logic        ldReq,
	input  wire logic [15:0] ldVal,
	output var  logic        frameStart,
	output var  logic        frameEnd,
	output var  logic        eepromLoad,
	output var  logic [15:0] eepromAlias
);
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			frameStart <= 1'b0;
			frameEnd <= 1'b0;
			eepromLoad <= 1'b0;
			eepromAlias <= 16'h0000;
		end else begin
			frameStart <= openReq;
			frameEnd <= closeReq;
			eepromLoad <= ldReq;
			// off the load cycle the bus toggles, so a stale value never looks valid
			eepromAlias <= ldReq ? ldVal : ~eepromAlias;
		end
	end
endmodule // sinfo_frame_model
`default_nettype wire

// [verification/sinfo_regs_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module sinfo_regs_chk (
	input wire logic        clk_sys,
	input wire logic        rst_n,
	input wire logic        frameStart,
	input wire logic        frameEnd,
	input wire logic        netRead,
	input wire logic        netWrite,
	input wire logic [15:0] netAddr,
	input wire logic [7:0]  netRdata,
	input wire logic        netWriteAck,
	input wire logic        hostRead,
	input wire logic [15:0] hostAddr,
	input wire logic [7:0]  hostRdata,
	input wire logic        guardActive
);
	logic opened;
	logic prot;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			opened <= 1'b0;
		end else if (frameStart || frameEnd) begin
			opened <= 1'b0;
		end else if (netWrite && netAddr == 16'h0020) begin
			opened <= 1'b1;
		end
	end
	assign prot = (netAddr <= 16'h0137 || (netAddr >= 16'h013A && netAddr <= 16'h0F0F))
		&& netAddr != 16'h0030 && netAddr != 16'h0020;
	AST_BMCOUNT: assert property (
		netRead && netAddr == 16'h0005 |=> netRdata == 8'h08) else $error("bm count");
	AST_RAMSIZE: assert property (
		hostRead && hostAddr == 16'h0006 |=> hostRdata == 8'h10) else $error("ram size");
	AST_PORTDESC: assert property (
		netRead && netAddr == 16'h0007 |-> ##1 netRdata == 8'h0F) else $error("port desc");
	AST_FEAT_BP: assert property (
		netRead && netAddr == 16'h0008 |=> netRdata[5:4] == 2'h0) else $error("feat bp");
	AST_FEAT_RSV: assert property (
		hostRead && hostAddr == 16'h0009 ##1 !hostRead
		|-> hostRdata[7:4] == 4'h0 ##1 hostRdata == 8'h00) else $error("feat rsv");
	AST_UNLOCK_RD: assert property (
		netRead && netAddr == 16'h0020 |=> netRdata == 8'h00) else $error("unlock rd");
	// guardActive lags the guard bit one cycle, so it is read with the ack
	AST_BLOCKED: assert property (
		netWrite && !opened && prot ##1 guardActive |-> !netWriteAck) else $error("blocked");
	AST_UNLOCKED: assert property (
		netWrite && opened && netAddr == 16'h0010 |=> netWriteAck) else $error("unlocked");
	AST_FREE: assert property (
		netWrite && netAddr == 16'h0010 ##1 !guardActive |-> netWriteAck) else $error("free");
endmodule // sinfo_regs_chk
bind sinfo_regs sinfo_regs_chk u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
	.frameStart(frameStart), .frameEnd(frameEnd), .netRead(netRead),
	.netWrite(netWrite), .netAddr(netAddr), .netRdata(netRdata),
	.netWriteAck(netWriteAck), .hostRead(hostRead), .hostAddr(hostAddr),
	.hostRdata(hostRdata), .guardActive(guardActive));
`default_nettype wire

// [verification/slave_info_and_write_protect_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module slave_info_and_write_protect_bench;
	logic        clk_sys, rst_n, netRead, netWrite, hostRead, hostWrite, aliasEnable;
	logic        frameStart, frameEnd, eepromLoad, netWriteAck, addrMatch, guardActive;
	logic        openReq, closeReq, ldReq;
	logic [15:0] netAddr, hostAddr, cmdAddr, ldVal, eepromAlias;
	logic [7:0]  netWdata, hostWdata, netRdata, hostRdata;
	int          errors, n_tests;
	sinfo_regs u_sinfo_regs (.clk_sys(clk_sys), .rst_n(rst_n), .frameStart(frameStart),
		.frameEnd(frameEnd), .netRead(netRead), .netWrite(netWrite), .netAddr(netAddr),
		.netWdata(netWdata), .netRdata(netRdata), .netWriteAck(netWriteAck),
		.hostRead(hostRead), .hostWrite(hostWrite), .hostAddr(hostAddr),
		.hostWdata(hostWdata), .hostRdata(hostRdata), .eepromLoad(eepromLoad),
		.eepromAlias(eepromAlias), .aliasEnable(aliasEnable), .cmdAddr(cmdAddr),
		.addrMatch(addrMatch), .guardActive(guardActive));
	sinfo_frame_model u_sinfo_frame_model (.clk_sys(clk_sys), .rst_n(rst_n),
		.openReq(openReq), .closeReq(closeReq), .ldReq(ldReq), .ldVal(ldVal),
		.frameStart(frameStart), .frameEnd(frameEnd), .eepromLoad(eepromLoad),
		.eepromAlias(eepromAlias));
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		n_tests++;
		if (s !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	// one byte access; an empty name skips the ack check
	task automatic acc(input logic h, input logic w, input logic [15:0] a,
		input logic [7:0] d, input logic [7:0] e, input string n);
		@(negedge clk_sys);
		{netAddr, hostAddr, netWdata, hostWdata} = {a, a, d, d};
		{netRead, netWrite, hostRead, hostWrite} = {!h && !w, !h && w, h && !w, h && w};
		@(negedge clk_sys);
		if (!w) chk(n, h ? hostRdata : netRdata, e);
		else if (!h && n != "") chk(n, {7'h00, netWriteAck}, e);
		{netRead, netWrite, hostRead, hostWrite} = 4'h0;
	endtask
	// 0 opens a frame, 1 closes it, 2 loads the EEPROM alias
	task automatic pulse(input int k, input logic [15:0] v);
		@(negedge clk_sys);
		{ldVal, openReq, closeReq, ldReq} = {v, k == 0, k == 1, k == 2};
		@(negedge clk_sys);
		{openReq, closeReq, ldReq} = 3'h0;
		@(negedge clk_sys);
	endtask
	task automatic mt(input logic al, input logic [15:0] ca, input logic [7:0] e);
		@(negedge clk_sys);
		{aliasEnable, cmdAddr} = {al, ca};
		@(negedge clk_sys);
		chk("addrMatch", {7'h00, addrMatch}, e);
	endtask
	task automatic end_of_test;
		if (errors == 0 && n_tests > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial begin
		repeat (1000) @(posedge clk_sys);
		errors++;
		end_of_test();
	end
	initial begin
		{rst_n, netRead, netWrite, hostRead, hostWrite, aliasEnable} = 6'h00;
		{netAddr, hostAddr, cmdAddr, ldVal, netWdata, hostWdata} = 80'h0;
		{openReq, closeReq, ldReq} = 3'h0;
		errors = 0;
		n_tests = 0;
		repeat (6) @(negedge clk_sys);
		rst_n = 1'b1;
		acc(0, 0, 16'h0005, 8'h00, 8'h08, "bmNet");
		acc(1, 0, 16'h0005, 8'h00, 8'h08, "bmHost");
		acc(1, 1, 16'h0006, 8'h55, 8'h00, "");
		acc(0, 0, 16'h0006, 8'h00, 8'h10, "ramSize");
		acc(0, 0, 16'h0007, 8'h00, 8'h0F, "portDesc");
		acc(0, 0, 16'h0008, 8'h00, 8'h0D, "featLo");
		acc(1, 0, 16'h0009, 8'h00, 8'h00, "featHi");
		pulse(2, 16'hBEEF);
		pulse(2, 16'h1234);
		acc(1, 0, 16'h0012, 8'h00, 8'hEF, "aliasLo");
		acc(0, 0, 16'h0013, 8'h00, 8'hBE, "aliasHi");
		acc(0, 1, 16'h0010, 8'h34, 8'h01, "staLoWr");
		acc(0, 1, 16'h0011, 8'h12, 8'h01, "staHiWr");
		acc(1, 1, 16'h0010, 8'hFF, 8'h00, "");
		acc(1, 0, 16'h0010, 8'h00, 8'h34, "staLo");
		acc(1, 1, 16'h0012, 8'h56, 8'h00, "");
		acc(0, 1, 16'h0013, 8'hAA, 8'h00, "");
		acc(0, 0, 16'h0013, 8'h00, 8'hBE, "aliasNet");
		acc(0, 0, 16'h0012, 8'h00, 8'h56, "aliasHost");
		mt(1, 16'hBE56, 8'h01);
		mt(0, 16'hBE56, 8'h00);
		mt(0, 16'h1234, 8'h01);
		acc(0, 1, 16'h0021, 8'hFF, 8'h01, "guardWr");
		acc(0, 0, 16'h0021, 8'h00, 8'h01, "guardRd");
		chk("guardActive", {7'h00, guardActive}, 8'h01);
		pulse(0, 16'h0000);
		acc(0, 1, 16'h0010, 8'h77, 8'h00, "blocked");
		acc(0, 0, 16'h0010, 8'h00, 8'h34, "kept");
		acc(0, 1, 16'h0030, 8'h00, 8'h01, "exempt");
		acc(0, 1, 16'h0138, 8'h00, 8'h01, "gap");
		acc(0, 1, 16'h0020, 8'hFF, 8'h01, "unlock");
		acc(0, 0, 16'h0020, 8'h00, 8'h00, "unlockRd");
		acc(0, 1, 16'h0010, 8'h77, 8'h01, "openWr");
		pulse(1, 16'h0000);
		pulse(0, 16'h0000);
		acc(0, 1, 16'h0011, 8'h99, 8'h00, "relocked");
		acc(0, 1, 16'h0F0F, 8'h00, 8'h00, "rangeEnd");
		acc(0, 1, 16'h0F10, 8'h00, 8'h01, "pastRange");
		acc(1, 0, 16'h0010, 8'h00, 8'h77, "staFinal");
		end_of_test();
	end
endmodule // slave_info_and_write_protect_bench
`default_nettype wire
